// [rtl/crx_core.sv]
`timescale 1ns/1ps
`default_nettype none
module crx_core #(
    parameter int ADDR_W = crx_pkg::ADDR_W,
    parameter int BANK_W = crx_pkg::BANK_W
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // instruction
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR,
    // configuration
    input wire logic EXT_EN,
    input wire logic [BANK_W-1:0] BANK_SEL,
    input wire logic [ADDR_W-1:0] INDEX_BASE,
    // data memory
    input wire logic [7:0] MEM_RDATA,
    output logic [ADDR_W-1:0] MEM_ADDR,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [7:0] MEM_WDATA,
    // results
    output logic [7:0] WREG,
    output logic FLAG_N,
    output logic FLAG_Z,
    output logic [1:0] PHASE,
    output logic DONE,
    output logic INDEXED
);
    crx_pkg::crx_phase_t phase_q, phase_d;
    logic busy_q, busy_d;
    logic dest_q, dest_d;
    logic [7:0] f_q, f_d;
    logic ram_q, ram_d;
    logic [7:0] data_q, data_d;
    logic [7:0] w_q, w_d;
    logic n_q, n_d, z_q, z_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic rd_q, rd_d, wr_q, wr_d, done_q, done_d, idx_q, idx_d;
    logic [ADDR_W-1:0] addr_c;
    logic idx_c;
    logic is_comp;

    assign is_comp = INSTR_VALID && (INSTR[crx_pkg::OPC_MSB:crx_pkg::OPC_LSB] == crx_pkg::OPC_COMP);

    crx_addr_gen #(
        .ADDR_W(ADDR_W),
        .BANK_W(BANK_W)
    ) u_addr (
        .f_operand(f_q),
        .ram_sel(ram_q),
        .ext_en(EXT_EN),
        .bank_sel(BANK_SEL),
        .index_base(INDEX_BASE),
        .addr(addr_c),
        .indexed(idx_c)
    );

    // one instruction spans four clocks, one per quarter phase
    always_comb begin
        phase_d = phase_q;
        busy_d = busy_q;
        dest_d = dest_q;
        f_d = f_q;
        ram_d = ram_q;
        data_d = data_q;
        w_d = w_q;
        n_d = n_q;
        z_d = z_q;
        addr_d = addr_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        done_d = 1'b0;
        idx_d = idx_q;
        case (phase_q)
            crx_pkg::CRX_Q1: begin
                // decode; other opcodes pass as a no-op cycle
                busy_d = is_comp;
                if (is_comp) begin
                    dest_d = INSTR[crx_pkg::DEST_BIT];
                    ram_d = INSTR[crx_pkg::RAM_BIT];
                    f_d = INSTR[7:0];
                end
                phase_d = crx_pkg::CRX_Q2;
            end
            crx_pkg::CRX_Q2: begin
                if (busy_q) begin
                    addr_d = addr_c;
                    idx_d = idx_c;
                    rd_d = 1'b1;
                end
                phase_d = crx_pkg::CRX_Q3;
            end
            crx_pkg::CRX_Q3: begin
                // memory answers combinationally while the read strobe stands
                if (busy_q) begin
                    data_d = ~MEM_RDATA;
                end
                phase_d = crx_pkg::CRX_Q4;
            end
            crx_pkg::CRX_Q4: begin
                if (busy_q) begin
                    if (dest_q) begin
                        wr_d = 1'b1;
                    end else begin
                        w_d = data_q;
                    end
                    n_d = data_q[7];
                    z_d = (data_q == 8'h00);
                    done_d = 1'b1;
                end
                busy_d = 1'b0;
                phase_d = crx_pkg::CRX_Q1;
            end
            default: begin
                phase_d = crx_pkg::CRX_Q1;
                busy_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            phase_q <= crx_pkg::CRX_Q1;
            busy_q <= 1'b0;
            dest_q <= 1'b1;
            f_q <= 8'h00;
            ram_q <= 1'b0;
            data_q <= crx_pkg::RESULT_RESET;
            w_q <= crx_pkg::W_RESET;
            n_q <= 1'b0;
            z_q <= 1'b0;
            addr_q <= crx_pkg::ADDR_RESET;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            done_q <= 1'b0;
            idx_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            busy_q <= busy_d;
            dest_q <= dest_d;
            f_q <= f_d;
            ram_q <= ram_d;
            data_q <= data_d;
            w_q <= w_d;
            n_q <= n_d;
            z_q <= z_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            done_q <= done_d;
            idx_q <= idx_d;
        end
    end

    assign MEM_ADDR = addr_q;
    assign MEM_RD = rd_q;
    assign MEM_WR = wr_q;
    assign MEM_WDATA = data_q;
    assign WREG = w_q;
    assign FLAG_N = n_q;
    assign FLAG_Z = z_q;
    assign PHASE = phase_q;
    assign DONE = done_q;
    assign INDEXED = idx_q;

    // outputs are registered, so expectations trail their cause by one or more edges
    a_invert_result: assert property (@(posedge CLK) disable iff (RST)
        MEM_RD |=> (MEM_WDATA == ~$past(MEM_RDATA)))
        else $error("result is not the inverse of read data");
    a_dest_wreg: assert property (@(posedge CLK) disable iff (RST)
        (DONE && !MEM_WR) |-> (WREG == ~$past(MEM_RDATA, 2) && WREG == MEM_WDATA))
        else $error("working register not loaded");
    a_dest_mem: assert property (@(posedge CLK) disable iff (RST)
        MEM_WR |-> (MEM_ADDR == $past(MEM_ADDR, 2) && DONE && $stable(WREG)))
        else $error("write-back address or working register wrong");
    a_access_bank: assert property (@(posedge CLK) disable iff (RST)
        (MEM_RD && !ram_q && !INDEXED) |->
        (MEM_ADDR[7:0] == f_q &&
        MEM_ADDR[ADDR_W-1:8] == ((f_q < crx_pkg::ACC_SPLIT) ? {BANK_W{1'b0}} : crx_pkg::SFR_BANK)))
        else $error("access bank address wrong");
    a_bank_addr: assert property (@(posedge CLK) disable iff (RST)
        (MEM_RD && ram_q) |-> (MEM_ADDR == {$past(BANK_SEL), f_q}))
        else $error("banked address wrong");
    a_indexed_mode: assert property (@(posedge CLK) disable iff (RST)
        MEM_RD |-> (INDEXED == ($past(EXT_EN) && !ram_q && f_q <= crx_pkg::IDX_LIMIT)))
        else $error("indexed mode selection wrong");
    a_quarter_seq: assert property (@(posedge CLK) disable iff (RST)
        (PHASE == 2'd1 && busy_q) |=> MEM_RD ##1 !MEM_RD ##1 DONE ##1 (PHASE == 2'd1))
        else $error("quarter phase sequence wrong");
    a_flags: assert property (@(posedge CLK) disable iff (RST)
        DONE |-> (FLAG_Z == (MEM_WDATA == 8'h00) && FLAG_N == MEM_WDATA[7]))
        else $error("flags do not match result");
    a_idle_slot: assert property (@(posedge CLK) disable iff (RST)
        (PHASE == 2'd0 && !is_comp) |-> ##2 !MEM_RD ##2 (!DONE && !MEM_WR))
        else $error("idle slot touched memory");
    a_wreg_no_write: assert property (@(posedge CLK) disable iff (RST)
        (PHASE == 2'd3 && busy_q && !dest_q) |=> (DONE && !MEM_WR))
        else $error("working register destination wrote memory");
    a_write_pulse: assert property (@(posedge CLK) disable iff (RST)
        MEM_WR |=> !MEM_WR)
        else $error("write strobe longer than one cycle");
    a_flags_quiet: assert property (@(posedge CLK) disable iff (RST)
        !DONE |-> ($stable(FLAG_N) && $stable(FLAG_Z)))
        else $error("flags changed outside completion");
    a_wreg_quiet: assert property (@(posedge CLK) disable iff (RST)
        !(DONE && !MEM_WR) |-> $stable(WREG))
        else $error("working register changed without cause");
    c_to_wreg: cover property (@(posedge CLK) disable iff (RST) DONE && !MEM_WR);
    c_to_mem: cover property (@(posedge CLK) disable iff (RST) MEM_WR);
    c_indexed: cover property (@(posedge CLK) disable iff (RST) MEM_RD && INDEXED);
    c_zero: cover property (@(posedge CLK) disable iff (RST) DONE && FLAG_Z);
endmodule // crx_core
`default_nettype wire

// [rtl/crx_pkg.sv]
`default_nettype none
package crx_pkg;
    // opcode high six bits of the complement-register instruction (0001_11da)
    localparam logic [5:0] OPC_COMP = 6'h07;
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 10;
    localparam int DEST_BIT = 9;
    localparam int RAM_BIT = 8;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam logic [7:0] IDX_LIMIT = 8'h5f;
    // access bank split: low part maps to bank 0, the rest to the special-function bank
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [3:0] SFR_BANK = 4'hf;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
    typedef enum logic [1:0] {
        CRX_Q1,
        CRX_Q2,
        CRX_Q3,
        CRX_Q4
    } crx_phase_t;
endpackage
`default_nettype wire

// [rtl/crx_addr_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module crx_addr_gen #(
    parameter int ADDR_W = 12,
    parameter int BANK_W = 4
) (
    input wire logic [7:0] f_operand,
    input wire logic ram_sel,
    input wire logic ext_en,
    input wire logic [BANK_W-1:0] bank_sel,
    input wire logic [ADDR_W-1:0] index_base,
    output logic [ADDR_W-1:0] addr,
    output logic indexed
);
    always_comb begin
        indexed = 1'b0;
        if (ram_sel) begin
            addr = {bank_sel, f_operand};
        end else if (ext_en && (f_operand <= crx_pkg::IDX_LIMIT)) begin
            // literal offset added to the index pointer; wraps within data space
            addr = index_base + {{(ADDR_W-8){1'b0}}, f_operand};
            indexed = 1'b1;
        end else if (f_operand < crx_pkg::ACC_SPLIT) begin
            addr = {{BANK_W{1'b0}}, f_operand};
        end else begin
            addr = {crx_pkg::SFR_BANK, f_operand};
        end
    end
endmodule // crx_addr_gen
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst, instr_valid, ext_en, mem_rd, mem_wr, flag_n, flag_z, done, indexed;
    logic [15:0] instr;
    logic [3:0] bank_sel;
    logic [11:0] index_base, mem_addr;
    logic [7:0] mem_rdata, mem_wdata, wreg;
    logic [1:0] phase;
    logic [7:0] mem [0:4095];
    int bad_count = 0;
    int cmp_count = 0;

    crx_core u_dut (.CLK(clk), .RST(rst), .INSTR_VALID(instr_valid), .INSTR(instr), .EXT_EN(ext_en),
        .BANK_SEL(bank_sel), .INDEX_BASE(index_base), .MEM_RDATA(mem_rdata), .MEM_ADDR(mem_addr),
        .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .WREG(wreg), .FLAG_N(flag_n),
        .FLAG_Z(flag_z), .PHASE(phase), .DONE(done), .INDEXED(indexed));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // unselected memory shows inverted data, so a read outside the strobe is caught
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
    always @(posedge clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // offer one instruction at the next Q1 and watch a whole slot; idle slots hold a foreign opcode
    task automatic op(input logic [5:0] opc, input logic d, input logic a, input logic [7:0] f,
                      input logic ext, input logic [3:0] bank, input logic [11:0] base, input logic [7:0] data);
        logic [11:0] ea;
        logic ei;
        logic [7:0] res, w0;
        logic [1:0] nz0;
        int rd_at, done_at, rd_n, wr_n, k;
        ei = ext && !a && (f <= 8'h5f);
        if (a) ea = {bank, f};
        else if (ei) ea = base + {4'h0, f};
        else if (f < 8'h60) ea = {4'h0, f};
        else ea = {4'hf, f};
        res = ~data;
        w0 = wreg;
        nz0 = {flag_n, flag_z};
        mem[ea] = data;
        rd_at = 0;
        done_at = 0;
        rd_n = 0;
        wr_n = 0;
        k = 0;
        @(posedge clk);
        #1;
        // phase is read settled; the offer goes out on the edge that opens the next slot
        while (phase !== 2'd3 && k < 8) begin
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
        instr <= {opc, d, a, f};
        ext_en <= ext;
        bank_sel <= bank;
        index_base <= base;
        @(posedge clk);
        instr <= 16'h0000;
        for (k = 1; k <= 6; k++) begin
            @(posedge clk);
            #1;
            if (mem_rd === 1'b1) begin
                rd_n++;
                rd_at = k;
                chk(16'(mem_addr), 16'(ea));
                chk(16'(indexed), 16'(ei));
            end
            if (mem_wr === 1'b1) wr_n++;
            if (done === 1'b1) begin
                done_at = k;
                chk(16'(flag_n), 16'(res[7]));
                chk(16'(flag_z), 16'(res == 8'h00));
            end
        end
        if (opc != 6'h07 || instr_valid !== 1'b1) begin
            chk(16'(rd_n + wr_n + done_at), 16'h0000);
            chk(16'(wreg), 16'(w0));
            chk(16'(mem[ea]), 16'(data));
            chk(16'({flag_n, flag_z}), 16'(nz0));
        end else begin
            chk(16'(rd_n), 16'h0001);
            chk(16'(done_at - rd_at), 16'h0002);
            if (d) begin
                chk(16'(mem[ea]), 16'(res));
                chk(16'(wr_n), 16'h0001);
            end else begin
                chk(16'(wreg), 16'(res));
                chk(16'(mem[ea]), 16'(data));
                chk(16'(wr_n), 16'h0000);
            end
        end
    endtask

    task automatic t_to_wreg();
        op(6'h07, 1'b0, 1'b1, 8'h13, 1'b0, 4'h3, 12'h000, 8'h13);
        op(6'h07, 1'b0, 1'b0, 8'h7f, 1'b0, 4'h3, 12'h000, 8'h00);
    endtask

    task automatic t_to_mem();
        op(6'h07, 1'b1, 1'b0, 8'h20, 1'b0, 4'h3, 12'h000, 8'hff);
        op(6'h07, 1'b1, 1'b0, 8'h80, 1'b1, 4'h3, 12'h000, 8'h01);
        op(6'h07, 1'b1, 1'b1, 8'hff, 1'b0, 4'hc, 12'h000, 8'h5a);
    endtask

    task automatic t_indexed();
        op(6'h07, 1'b0, 1'b0, 8'h5f, 1'b1, 4'h5, 12'hffe, 8'h80);
        op(6'h07, 1'b1, 1'b0, 8'h60, 1'b1, 4'h5, 12'h100, 8'h33);
        op(6'h07, 1'b1, 1'b1, 8'h10, 1'b1, 4'ha, 12'h200, 8'h0f);
    endtask

    // neighbouring opcodes must leave memory and flags alone
    task automatic t_refuse();
        op(6'h06, 1'b1, 1'b0, 8'h21, 1'b0, 4'h0, 12'h000, 8'h44);
        op(6'h0f, 1'b0, 1'b1, 8'h22, 1'b0, 4'h1, 12'h000, 8'h55);
        // a matching opcode without its valid qualifier is an idle slot too
        @(posedge clk);
        instr_valid <= 1'b0;
        op(6'h07, 1'b1, 1'b0, 8'h23, 1'b0, 4'h2, 12'h000, 8'h66);
        @(posedge clk);
        instr_valid <= 1'b1;
    endtask

    initial begin
        rst = 1'b1;
        instr_valid = 1'b1;
        instr = 16'h0000;
        ext_en = 1'b0;
        bank_sel = 4'h0;
        index_base = 12'h000;
        for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_to_wreg();
        t_to_mem();
        t_indexed();
        t_refuse();
        wrap_up();
    end

    // each slot takes under 20 cycles; this bound is several times the whole run
    initial begin
        #20000;
        bad_count++;
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
